/* logic/bsl_boot_strap_latch.sv */
// Boot strap latch: samples strap pins in reset, decodes boot settings
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "bsl_defs.svh"

module bsl_boot_strap_latch (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // Reset sources
   input  wire logic                    moduleEnable,
   input  wire logic                    sysResetReq,
   // Strap pins
   input  wire bsl_pkg::bsl_straps_t    strapPinIn,
   output var  logic [4:0]              pullUpEn,
   output var  logic [4:0]              pullDownEn,
   output var  logic                    pinsReleased,
   // Boot configuration
   output var  bsl_pkg::bsl_cfg_t       bootCfg,
   output var  logic                    deviceRunning,
   // APB
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`BSL_ADDR_W-1:0]  paddr,
   input  wire logic [`BSL_DATA_W-1:0]  pwdata,
   output var  logic [`BSL_DATA_W-1:0]  prdata,
   output var  logic                    pready,
   output var  logic                    pslverr
);

   localparam logic [4:0] PULL_MASK = `BSL_PULLUP_MASK;

   bsl_pkg::bsl_state_t  state_q;
   bsl_pkg::bsl_state_t  state_d;
   bsl_pkg::bsl_straps_t straps_q;
   bsl_pkg::bsl_cfg_t    cfg_d;
   logic [`BSL_OVR_W-1:0] ovr;

   // Any reset source holds the block in capture
   wire logic inReset   = !moduleEnable || sysResetReq;
   wire logic capturing = (state_q == bsl_pkg::BSL_ST_CAPTURE);
   wire logic running   = (state_q == bsl_pkg::BSL_ST_RUN);

   // Override applies only once booted
   wire logic ovrVolt = running && ovr[`BSL_OVR_VOLT_EN];
   wire logic ovrSdio = running && ovr[`BSL_OVR_SDIO_EN];

   // Download boot with the qualifier high is a board fault
   wire logic conflict = !straps_q.bootSel && straps_q.dlQual;

   // Next state
   always_comb begin
      case (state_q)
         bsl_pkg::BSL_ST_CAPTURE: begin
            state_d = inReset ? bsl_pkg::BSL_ST_CAPTURE : bsl_pkg::BSL_ST_RUN;
         end
         bsl_pkg::BSL_ST_RUN: begin
            state_d = inReset ? bsl_pkg::BSL_ST_CAPTURE : bsl_pkg::BSL_ST_RUN;
         end
         default: begin
            state_d = bsl_pkg::BSL_ST_CAPTURE;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= bsl_pkg::BSL_ST_CAPTURE;
      end else begin
         state_q <= state_d;
      end
   end

   // Strap latch: tracks pins in capture, frozen once running.
   // The last sample before release is what the device boots with.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         straps_q <= `BSL_STRAP_RST;
      end else if (capturing) begin
         straps_q <= strapPinIn;
      end
   end

   // Setting decode
   always_comb begin
      cfg_d.volt18Sel      = ovrVolt ? ovr[`BSL_OVR_VOLT_18]
                                     : straps_q.ioVolt;
      cfg_d.bootFlash      = straps_q.bootSel;
      cfg_d.downloadBoot   = !straps_q.bootSel;
      cfg_d.logEnable      = straps_q.logEdge;
      cfg_d.sdioSampleRise = ovrSdio ? ovr[`BSL_OVR_SMP_RISE]
                                     : straps_q.logEdge;
      cfg_d.sdioDriveRise  = ovrSdio ? ovr[`BSL_OVR_DRV_RISE]
                                     : straps_q.sdioEdgeB;
   end

   // Output registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bootCfg       <= '0;
         deviceRunning <= 1'b0;
         pinsReleased  <= 1'b0;
      end else begin
         bootCfg       <= cfg_d;
         deviceRunning <= running;
         pinsReleased  <= running;
      end
   end

   // One pull controller per strap pin
   for (genvar i = 0; i < `BSL_NUM_STRAPS; i++) begin : gPull
      bsl_pad_pull #(
         .DEFAULT_HIGH (PULL_MASK[i])
      ) uPull (
         .mclk       (mclk),
         .rst        (rst),
         .pullActive (capturing),
         .pullUpEn   (pullUpEn[i]),
         .pullDownEn (pullDownEn[i])
      );
   end

   // Register file
   bsl_apb_regs uRegs (
      .mclk    (mclk),
      .rst     (rst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .capture (straps_q),
      .status  ({conflict, running, cfg_d}),
      .ovr     (ovr)
   );

   // Cycles spent running, saturating; feeds the long-hold cover only
   logic [3:0]       runLen_q;
   wire  logic [3:0] runLen_d = !running ? 4'h0 :
                                (runLen_q == 4'hF) ? runLen_q : runLen_q + 4'h1;

   // Run-length register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         runLen_q <= 4'h0;
      end else begin
         runLen_q <= runLen_d;
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   latchFrozen_a: assert property (
      running && $past(running) |-> $stable(straps_q))
      else $error("held strap bits changed while running");

   captureSample_a: assert property (
      capturing |=> straps_q == $past(strapPinIn))
      else $error("strap latch missed the pin level in capture");

   pullsOnReset_a: assert property (
      capturing |=> pullUpEn == PULL_MASK && pullDownEn == ~PULL_MASK)
      else $error("pulls not applied during capture");

   pinsRelease_a: assert property (
      running |=> pullUpEn == 5'h00 && pullDownEn == 5'h00 && pinsReleased)
      else $error("pins not released after reset");

   // Sampled reset in the antecedent: outputs reset to zero while the held
   // straps reset to the pull defaults, so the release edge compares unlike values
   voltSelect_a: assert property (
      !rst && !ovrVolt |=> bootCfg.volt18Sel == $past(straps_q.ioVolt))
      else $error("voltage select does not follow strap");

   bootSelect_a: assert property (
      !rst |=> bootCfg.bootFlash == $past(straps_q.bootSel)
          && bootCfg.downloadBoot == !$past(straps_q.bootSel))
      else $error("boot mode does not follow strap");

   logEnable_a: assert property (
      !rst |=> bootCfg.logEnable == $past(straps_q.logEdge))
      else $error("log enable does not follow strap");

   sdioEdges_a: assert property (
      !rst && !ovrSdio |=> {bootCfg.sdioSampleRise, bootCfg.sdioDriveRise}
                   == $past({straps_q.logEdge, straps_q.sdioEdgeB}))
      else $error("SDIO edges do not follow straps");

   overrideUse_a: assert property (
      ovrVolt && ovrSdio |=> bootCfg.volt18Sel == $past(ovr[`BSL_OVR_VOLT_18])
         && bootCfg.sdioDriveRise == $past(ovr[`BSL_OVR_DRV_RISE]))
      else $error("override bits not applied");

   enableLow_a: assert property (
      !moduleEnable |=> capturing ##1 !deviceRunning)
      else $error("low enable did not hold the block in reset");

   sysResetEntry_a: assert property (
      sysResetReq |=> capturing)
      else $error("system reset request did not start a capture");

   holdInReset_a: assert property (
      inReset |=> capturing)
      else $error("block left capture while a reset source was active");

   releaseToRun_a: assert property (
      capturing && !inReset |=> running)
      else $error("block did not run after reset release");

   runFlags_a: assert property (
      !rst |=> deviceRunning == $past(running) && pinsReleased == $past(running))
      else $error("running flags lag the state by more than one edge");

   overrideVolt_a: assert property (
      ovrVolt |=> bootCfg.volt18Sel == $past(ovr[`BSL_OVR_VOLT_18]))
      else $error("voltage override not applied");

   overrideSdio_a: assert property (
      ovrSdio |=> bootCfg.sdioSampleRise == $past(ovr[`BSL_OVR_SMP_RISE])
         && bootCfg.sdioDriveRise == $past(ovr[`BSL_OVR_DRV_RISE]))
      else $error("SDIO edge override not applied");

   // Override bits survive a re-capture but must stay out of the settings then
   noOvrCapture_a: assert property (
      !rst && capturing |=> bootCfg.volt18Sel == $past(straps_q.ioVolt)
         && bootCfg.sdioSampleRise == $past(straps_q.logEdge)
         && bootCfg.sdioDriveRise == $past(straps_q.sdioEdgeB))
      else $error("override leaked into the settings during capture");

   downloadDecode_a: assert property (
      !rst && !straps_q.bootSel && !straps_q.dlQual
         |=> bootCfg.downloadBoot && !bootCfg.bootFlash)
      else $error("download boot not selected by low boot straps");

   downloadBoot_c: cover property (
      running && !straps_q.bootSel && !straps_q.dlQual);
   overrideRun_c: cover property (running && ovrVolt && ovrSdio);
   reCapture_c: cover property (running ##1 capturing ##[1:8] running);
   sysRecapture_c: cover property (running && sysResetReq ##1 capturing);
   longRun_c: cover property (runLen_q == 4'hF);

endmodule

`default_nettype wire

/* include/bsl_defs.svh */
// Offsets, field positions, reset values and widths for the strap latch
`ifndef BSL_DEFS_SVH
`define BSL_DEFS_SVH

// Register bus geometry
`define BSL_ADDR_W        8
`define BSL_DATA_W        32
`define BSL_NUM_STRAPS    5

// Register byte offsets
`define BSL_OFS_CAPTURE   8'h00
`define BSL_OFS_OVERRIDE  8'h04
`define BSL_OFS_STATUS    8'h08

// Override register fields
`define BSL_OVR_VOLT_EN   0
`define BSL_OVR_VOLT_18   1
`define BSL_OVR_SDIO_EN   2
`define BSL_OVR_SMP_RISE  3
`define BSL_OVR_DRV_RISE  4
`define BSL_OVR_W         5
`define BSL_OVR_RST       5'h00

// Status register fields (bits 5:0 are the effective settings)
`define BSL_STAT_RUN      6
`define BSL_STAT_CONFLICT 7
`define BSL_STAT_W        8

// Pull defaults: 1 = pull-up, 0 = pull-down, bit order as the strap struct
`define BSL_PULLUP_MASK   5'h1A
`define BSL_STRAP_RST     5'h1A

`endif

/* include/bsl_pkg.sv */
// Types shared by the strap latch design
package bsl_pkg;

   // Strap pin levels, bit 4 first
   typedef struct packed {
      logic sdioEdgeB;
      logic logEdge;
      logic dlQual;
      logic bootSel;
      logic ioVolt;
   } bsl_straps_t;

   // Effective boot configuration
   typedef struct packed {
      logic volt18Sel;
      logic bootFlash;
      logic downloadBoot;
      logic logEnable;
      logic sdioSampleRise;
      logic sdioDriveRise;
   } bsl_cfg_t;

   typedef enum logic [0:0] {
      BSL_ST_CAPTURE = 1'b0,
      BSL_ST_RUN     = 1'b1
   } bsl_state_t;

endpackage

/* logic/bsl_pad_pull.sv */
// Weak pull control for one strap pin
`timescale 1ns/1ns
`default_nettype none

module bsl_pad_pull #(
   parameter bit DEFAULT_HIGH = 1'b0
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Control
   input  wire logic pullActive,
   // Pad pull enables
   output var  logic pullUpEn,
   output var  logic pullDownEn
);

   // Pulls are on from reset so a floating pin settles before sampling
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pullUpEn   <= DEFAULT_HIGH;
         pullDownEn <= !DEFAULT_HIGH;
      end else begin
         pullUpEn   <= pullActive && DEFAULT_HIGH;
         pullDownEn <= pullActive && !DEFAULT_HIGH;
      end
   end

endmodule

`default_nettype wire

/* logic/bsl_apb_regs.sv */
// APB slave holding the strap capture, override and status registers
`timescale 1ns/1ns
`default_nettype none
`include "bsl_defs.svh"

module bsl_apb_regs (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // APB
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`BSL_ADDR_W-1:0]  paddr,
   input  wire logic [`BSL_DATA_W-1:0]  pwdata,
   output var  logic [`BSL_DATA_W-1:0]  prdata,
   output var  logic                    pready,
   output var  logic                    pslverr,
   // Block side
   input  wire logic [4:0]              capture,
   input  wire logic [`BSL_STAT_W-1:0]  status,
   output var  logic [`BSL_OVR_W-1:0]   ovr
);

   // Address decode
   wire logic hitCap  = (paddr == `BSL_OFS_CAPTURE);
   wire logic hitOvr  = (paddr == `BSL_OFS_OVERRIDE);
   wire logic hitStat = (paddr == `BSL_OFS_STATUS);
   wire logic hitAny  = hitCap || hitOvr || hitStat;
   // One wait state: answer is registered in the first access cycle
   wire logic access  = psel && penable && !pready;
   wire logic wrDone  = psel && penable && pready && pwrite && hitOvr;

   // Read mux, unused upper bits read as zero
   wire logic [`BSL_DATA_W-1:0] rdMux =
      hitCap  ? {27'h0000000, capture} :
      hitOvr  ? {27'h0000000, ovr} :
      hitStat ? {24'h000000, status} : 32'h00000000;

   // Handshake and read data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= access;
         pslverr <= access && !hitAny;
         prdata  <= (access && !pwrite) ? rdMux : 32'h00000000;
      end
   end

   // Override bits, written on the completing edge only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovr <= `BSL_OVR_RST;
      end else if (wrDone) begin
         ovr <= pwdata[`BSL_OVR_W-1:0];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   capReadBack_a: assert property (
      access && !pwrite && hitCap |=> prdata[4:0] == $past(capture) && pready)
      else $error("capture register read returned wrong value");

endmodule

`default_nettype wire

/* bench/bsl_strap_host.sv */
// Board model: strap pulls and host GPIO drive on the five strap pins
`timescale 1ns/1ns
`default_nettype none

module bsl_strap_host (
   // Clock
   input  wire logic                 mclk,
   // Device pad pulls
   input  wire logic [4:0]           pullUpEn,
   input  wire logic [4:0]           pullDownEn,
   // Host GPIO control
   input  wire logic [4:0]           hostDrive,
   input  wire logic [4:0]           hostLevel,
   // Pin levels seen by the device
   output var  bsl_pkg::bsl_straps_t strapPinIn
);
   logic [4:0] lastQ;
   logic [4:0] pinLevel;

   initial lastQ = 5'h00;

   // Host wins, then pulls; a floating pin flips so no stale level survives
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pinLevel[i] = hostDrive[i] ? hostLevel[i] :
                       pullUpEn[i] ? 1'b1 : pullDownEn[i] ? 1'b0 : ~lastQ[i];
      end
   end

   // Voltage strap left to its pull-down unless a test drives it
   assign strapPinIn = bsl_pkg::bsl_straps_t'(pinLevel);

   always @(posedge mclk) lastQ <= pinLevel;
endmodule
`default_nettype wire

/* bench/bsl_boot_strap_latch_bench.sv */
// Self-checking bench for the boot strap latch
`timescale 1ns/1ns
`default_nettype none
`include "bsl_defs.svh"

module bsl_boot_strap_latch_bench;
   logic                    mclk = 1'b0;
   logic                    rst = 1'b1;
   logic                    moduleEnable = 1'b1;
   logic                    sysResetReq = 1'b0;
   bsl_pkg::bsl_straps_t    strapPinIn;
   logic [4:0]              pullUpEn;
   logic [4:0]              pullDownEn;
   logic                    pinsReleased;
   bsl_pkg::bsl_cfg_t       bootCfg;
   logic                    deviceRunning;
   logic                    psel = 1'b0;
   logic                    penable = 1'b0;
   logic                    pwrite = 1'b0;
   logic [`BSL_ADDR_W-1:0]  paddr = 8'h00;
   logic [31:0]             pwdata = 32'h0;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic [4:0]              hostDrive = 5'h00;
   logic [4:0]              hostLevel = 5'h00;
   logic [31:0]             rdData;
   logic                    rdErr;
   logic [4:0]              expStrap;
   logic [4:0]              pattern [4] = '{5'h00, 5'h13, 5'h0D, 5'h1E};
   int                      miscompares = 0;
   int                      checkCount = 0;
   int                      cycles = 0;

   always #20 mclk = ~mclk;

   bsl_boot_strap_latch DUT (.mclk(mclk), .rst(rst), .moduleEnable(moduleEnable),
      .sysResetReq(sysResetReq), .strapPinIn(strapPinIn), .pullUpEn(pullUpEn),
      .pullDownEn(pullDownEn), .pinsReleased(pinsReleased), .bootCfg(bootCfg),
      .deviceRunning(deviceRunning), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   bsl_strap_host HOST (.mclk(mclk), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
      .hostDrive(hostDrive), .hostLevel(hostLevel), .strapPinIn(strapPinIn));

   task automatic completeRun();
      if (miscompares == 0 && checkCount > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Hang guard: whole run needs well under this
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         completeRun();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Settings decoded from held straps, msb first
   function automatic logic [5:0] cfgOf(input logic [4:0] s);
      return {s[0], s[1], ~s[1], s[3], s[3], s[4]};
   endfunction

   // Re-capture through enable or system reset request, then check results
   task automatic cap(input logic useSys, input logic [4:0] lvl, input logic [4:0] drv);
      @(posedge mclk);
      if (useSys) sysResetReq <= 1'b1;
      else moduleEnable <= 1'b0;
      hostLevel <= lvl;
      hostDrive <= drv;
      repeat (3) @(posedge mclk);
      chk("pullUpEn", 32'(pullUpEn), 32'h1A);
      chk("pullDownEn", 32'(pullDownEn), 32'h05);
      chk("pinsReleased", 32'(pinsReleased), 32'h0);
      moduleEnable <= 1'b1;
      sysResetReq <= 1'b0;
      repeat (2) @(posedge mclk);
      hostLevel <= ~lvl;
      repeat (3) @(posedge mclk);
      expStrap = (drv & lvl) | (~drv & 5'h1A);
      chk("bootCfg", 32'(bootCfg), 32'(cfgOf(expStrap)));
      chk("running", 32'({pinsReleased, deviceRunning, pullUpEn, pullDownEn}), 32'hC00);
      apb(1'b0, `BSL_OFS_CAPTURE, 32'h0);
      chk("capture", rdData, 32'(expStrap));
      apb(1'b0, `BSL_OFS_STATUS, 32'h0);
      chk("status", rdData, {24'h0, ~expStrap[1] & expStrap[2], 1'b1, cfgOf(expStrap)});
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      chk("pullsInReset", {pullUpEn, pullDownEn}, 32'h345);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("defaultCfg", 32'(bootCfg), 32'h17);
      apb(1'b0, `BSL_OFS_CAPTURE, 32'h0);
      chk("defaultCapture", rdData, 32'h1A);
      foreach (pattern[i]) cap(1'b0, pattern[i], 5'h1F);
      cap(1'b1, 5'h05, 5'h05);
      apb(1'b1, `BSL_OFS_OVERRIDE, 32'h15);
      repeat (2) @(posedge mclk);
      chk("overrideCfg", 32'(bootCfg), 32'h15);
      apb(1'b0, `BSL_OFS_OVERRIDE, 32'h0);
      chk("overrideReg", rdData, 32'h15);
      apb(1'b1, `BSL_OFS_CAPTURE, 32'h0);
      apb(1'b0, `BSL_OFS_CAPTURE, 32'h0);
      chk("captureRo", {rdErr, rdData[30:0]}, 32'h1F);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", {rdErr, rdData[30:0]}, 32'h80000000);
      completeRun();
   end
endmodule
`default_nettype wire
